//--- core/dcfr_pkg.sv
// constants and register map of the diagnostic, clip and fault report registers
// Functional notes
// - Phase low byte, bits 7:0, is read-only and zero after reset.
// - Stimulus result high byte, bits 15:8, is read-only and zero after reset.
// - Stimulus result low byte, bits 7:0, is read-only and zero after reset.
// - Writing one to misc bit 7 clears latched faults; zero there is normal running.
// - Misc bit 5 at zero passes current-limit warnings to the warning pin; one hides them.
// - A current-limit warning rises when limiting fills over 45 percent of a 200 ms window.
// - More than four warning windows in a row raise a current-limit fault; outputs go high-Z.
// - Misc bit 3 at zero latches over-temperature faults; at one protection self-recovers.
// - Clip bit 4 clear routes all clip flags to warn; set routes ch1-2 to warn, ch3-4 to fault.
// - Clip detection runs only while clip bit 0 is one, and that bit is one after reset.
// - Clip status bits 3 to 0 read one while channels 4 to 1 are clipping.
// - Phase high byte, bits 15:8, is read-only and pairs with the phase low byte.
// - Read-only per-channel current-limit warning bits read one while a warning stands.
// - A separate enable makes clip reporting on the pins latched or live.
package dcfr_pkg;
	localparam logic [7:0] ADDR_PHASE_HI = 8'h1B;
	localparam logic [7:0] ADDR_PHASE_LO = 8'h1C;
	localparam logic [7:0] ADDR_STIM_HI = 8'h1D;
	localparam logic [7:0] ADDR_STIM_LO = 8'h1E;
	localparam logic [7:0] ADDR_MISC = 8'h21;
	localparam logic [7:0] ADDR_CLIP_CTL = 8'h22;
	localparam logic [7:0] ADDR_CLIP_STAT = 8'h24;
	localparam logic [7:0] ADDR_ILIM_STAT = 8'h25;
	localparam int MISC_CLEAR_BIT = 7;
	localparam int MISC_ILIM_MASK_BIT = 5;
	localparam int MISC_THERM_AUTO_BIT = 3;
	localparam int CLIP_ROUTE_BIT = 4;
	localparam int CLIP_LEVEL_LSB = 1;
	localparam int CLIP_EN_BIT = 0;
	localparam logic [7:0] MISC_RESET = 8'h00;
	localparam logic [7:0] MISC_WMASK = 8'h28;
	localparam logic [7:0] CLIP_CTL_RESET = 8'h01;
	localparam logic [7:0] CLIP_CTL_WMASK = 8'h17;
	localparam logic [7:0] DIAG_RESET = 8'h00;
	localparam int unsigned WINDOW_MS = 200;
	localparam int unsigned CLK_KHZ = 100000;
	localparam int unsigned WINDOW_CYCLES = WINDOW_MS * CLK_KHZ;
	localparam int unsigned WARN_PERCENT = 45;
	localparam int unsigned FAULT_WINDOWS = 4;
endpackage

//--- core/dcfr_ilim_mon.sv
// per-channel current-limit density monitor
`timescale 1ns/1ps
`default_nettype none
module dcfr_ilim_mon #(
	parameter int unsigned WINDOW = dcfr_pkg::WINDOW_CYCLES,
	parameter int unsigned CNT_W = 25,
	parameter int unsigned PERCENT = dcfr_pkg::WARN_PERCENT,
	parameter int unsigned RUNS = dcfr_pkg::FAULT_WINDOWS
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic windowEnd,
	input wire logic limitEvent,
	input wire logic clearFault,
	output logic warn,
	output logic fault
);
	localparam longint LIMIT = (longint'(WINDOW) * PERCENT) / 100;
	localparam logic [CNT_W:0] LIMIT_V = (CNT_W + 1)'(LIMIT);
	if (WINDOW < 2 || (longint'(1) << CNT_W) <= longint'(WINDOW) || RUNS > 6 || PERCENT > 100) begin
		$error("dcfr_ilim_mon: parameters out of range");
	end
	logic [CNT_W-1:0] hits;
	logic [2:0] runLen;
	logic [CNT_W:0] hitsNow;
	logic over;
	logic setFault;
	assign hitsNow = {1'b0, hits} + {{CNT_W{1'b0}}, limitEvent};
	assign over = windowEnd && (hitsNow > LIMIT_V);
	assign setFault = over && (runLen == 3'(RUNS));
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hits <= '0;
		end else if (windowEnd) begin
			hits <= '0;
		end else if (limitEvent) begin
			hits <= hitsNow[CNT_W-1:0];
		end
	end
	// warning follows the density of the last whole window
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			warn <= 1'b0;
			runLen <= 3'h0;
		end else if (windowEnd) begin
			warn <= over;
			runLen <= over ? ((runLen == 3'(RUNS)) ? runLen : runLen + 3'h1) : 3'h0;
		end
	end
	// set beats clear, so a fault on the clearing cycle survives
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fault <= 1'b0;
		end else if (setFault) begin
			fault <= 1'b1;
		end else if (clearFault) begin
			fault <= 1'b0;
		end
	end
	fault_needs_runs_a: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(fault) |-> $past(windowEnd) && $past(runLen) == 3'(RUNS))
		else $error("fault rose without enough warning windows");
	fault_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
		clearFault && !setFault |=> !fault)
		else $error("fault not cleared");
	warn_window_a: assert property (@(posedge mclk) disable iff (!nrst)
		!windowEnd |=> warn == $past(warn))
		else $error("warning changed inside a window");
endmodule
`default_nettype wire

//--- core/dcfr_regs.sv
// diagnostic report, clip control and fault control register bank
`timescale 1ns/1ps
`default_nettype none
module dcfr_regs #(
	parameter int unsigned WINDOW_CYCLES = dcfr_pkg::WINDOW_CYCLES,
	parameter int unsigned CHANNELS = 4
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	input wire logic diagValid,
	input wire logic [15:0] phaseIn,
	input wire logic [15:0] stimIn,
	input wire logic [3:0] clipRaw,
	input wire logic [3:0] limitEvent,
	input wire logic overTemp,
	input wire logic clipPinLatchEn,
	output logic warnPin,
	output logic faultPin,
	output logic outputsHiZ,
	output logic thermalShutdown,
	output logic clippingDetectorOn,
	output logic [1:0] clipThreshold
);
	localparam int unsigned CNT_W = $clog2(WINDOW_CYCLES + 1);
	if (CHANNELS != 4 || WINDOW_CYCLES < 2) begin
		$error("dcfr_regs: only four channels and a window of two or more cycles");
	end
	logic [7:0] phaseHi, phaseLo, stimulusResultUpper, stimulusResultLower;
	logic [7:0] miscCtl, clipCtl;
	logic [3:0] clipStatus, clipSticky, limitWarn, limitFault;
	logic faultClear;
	logic [CNT_W-1:0] windowCnt;
	logic windowEnd;
	logic [3:0] clipLive, clipPinSrc;
	logic [7:0] next_rdData;
	logic next_warn, next_fault, thermalSet;
	logic wrMisc, wrClip;
	assign wrMisc = regWrEn && regAddr == dcfr_pkg::ADDR_MISC;
	assign wrClip = regWrEn && regAddr == dcfr_pkg::ADDR_CLIP_CTL;
	// diagnostic results, written only by the measurement engine
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			phaseHi <= dcfr_pkg::DIAG_RESET;
			phaseLo <= dcfr_pkg::DIAG_RESET;
			stimulusResultUpper <= dcfr_pkg::DIAG_RESET;
			stimulusResultLower <= dcfr_pkg::DIAG_RESET;
		end else if (diagValid) begin
			phaseHi <= phaseIn[15:8];
			phaseLo <= phaseIn[7:0];
			stimulusResultUpper <= stimIn[15:8];
			stimulusResultLower <= stimIn[7:0];
		end
	end
	// writable bits only; the clear bit is a pulse and never stored
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			miscCtl <= dcfr_pkg::MISC_RESET;
			clipCtl <= dcfr_pkg::CLIP_CTL_RESET;
		end else begin
			if (wrMisc) begin
				miscCtl <= regWrData & dcfr_pkg::MISC_WMASK;
			end
			if (wrClip) begin
				clipCtl <= regWrData & dcfr_pkg::CLIP_CTL_WMASK;
			end
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			faultClear <= 1'b0;
		end else begin
			faultClear <= wrMisc && regWrData[dcfr_pkg::MISC_CLEAR_BIT];
		end
	end
	// one shared observation window for all channels
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			windowCnt <= '0;
		end else if (windowEnd) begin
			windowCnt <= '0;
		end else begin
			windowCnt <= windowCnt + CNT_W'(1);
		end
	end
	assign windowEnd = windowCnt == CNT_W'(WINDOW_CYCLES - 1);
	for (genvar ch = 0; ch < 4; ch++) begin : g_mon
		dcfr_ilim_mon #(
			.WINDOW(WINDOW_CYCLES),
			.CNT_W(CNT_W)
		) u_mon (
			.mclk(mclk),
			.nrst(nrst),
			.windowEnd(windowEnd),
			.limitEvent(limitEvent[ch]),
			.clearFault(faultClear),
			.warn(limitWarn[ch]),
			.fault(limitFault[ch])
		);
	end
	assign clipLive = clipRaw & {4{clipCtl[dcfr_pkg::CLIP_EN_BIT]}};
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			clipStatus <= 4'h0;
			clipSticky <= 4'h0;
		end else begin
			clipStatus <= clipLive;
			// new clipping wins over a clear in the same cycle
			clipSticky <= clipLive | (faultClear ? 4'h0 : clipSticky);
		end
	end
	assign clipPinSrc = clipPinLatchEn ? (clipSticky | clipLive) : clipLive;
	// in self-recover mode shutdown just tracks the sensor
	assign thermalSet = overTemp;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			thermalShutdown <= 1'b0;
		end else if (miscCtl[dcfr_pkg::MISC_THERM_AUTO_BIT]) begin
			thermalShutdown <= overTemp;
		end else if (thermalSet) begin
			thermalShutdown <= 1'b1;
		end else if (faultClear) begin
			thermalShutdown <= 1'b0;
		end
	end
	always_comb begin
		next_warn = !miscCtl[dcfr_pkg::MISC_ILIM_MASK_BIT] && (|limitWarn);
		next_fault = (|limitFault) || thermalShutdown;
		if (clipCtl[dcfr_pkg::CLIP_ROUTE_BIT]) begin
			next_warn = next_warn || (|clipPinSrc[1:0]);
			next_fault = next_fault || (|clipPinSrc[3:2]);
		end else begin
			next_warn = next_warn || (|clipPinSrc);
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			warnPin <= 1'b0;
			faultPin <= 1'b0;
			outputsHiZ <= 1'b0;
			clippingDetectorOn <= 1'b1;
			clipThreshold <= 2'h0;
		end else begin
			warnPin <= next_warn;
			faultPin <= next_fault;
			outputsHiZ <= (|limitFault) || thermalShutdown;
			clippingDetectorOn <= clipCtl[dcfr_pkg::CLIP_EN_BIT];
			// 00 2%, 01 5%, 10 10%, 11 1% THD; comparators decode it
			clipThreshold <= clipCtl[dcfr_pkg::CLIP_LEVEL_LSB +: 2];
		end
	end
	// read mux is pure: no register changes on a read
	always_comb begin
		next_rdData = 8'h00;
		case (regAddr)
			dcfr_pkg::ADDR_PHASE_HI: next_rdData = phaseHi;
			dcfr_pkg::ADDR_PHASE_LO: next_rdData = phaseLo;
			dcfr_pkg::ADDR_STIM_HI: next_rdData = stimulusResultUpper;
			dcfr_pkg::ADDR_STIM_LO: next_rdData = stimulusResultLower;
			dcfr_pkg::ADDR_MISC: next_rdData = miscCtl;
			dcfr_pkg::ADDR_CLIP_CTL: next_rdData = clipCtl;
			dcfr_pkg::ADDR_CLIP_STAT: next_rdData = {4'h0, clipStatus};
			dcfr_pkg::ADDR_ILIM_STAT: next_rdData = {limitFault, limitWarn};
			default: next_rdData = 8'h00;
		endcase
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			regRdData <= 8'h00;
		end else if (regRdEn) begin
			regRdData <= next_rdData;
		end
	end
	clear_pulse_a: assert property (@(posedge mclk) disable iff (!nrst)
		wrMisc && regWrData[dcfr_pkg::MISC_CLEAR_BIT] |=> faultClear ##1 !faultClear || $past(wrMisc, 1))
		else $error("clear pulse missing");
	misc_reserved_a: assert property (@(posedge mclk) disable iff (!nrst)
		regRdEn && regAddr == dcfr_pkg::ADDR_MISC |=> regRdData[7:6] == 2'h0 && regRdData[4] == 1'b0
		&& regRdData[2:0] == 3'h0)
		else $error("misc reserved or clear bit read nonzero");
	clip_ctl_rb_a: assert property (@(posedge mclk) disable iff (!nrst)
		wrClip ##1 !wrClip ##1 (regRdEn && regAddr == dcfr_pkg::ADDR_CLIP_CTL && !regWrEn)
		|=> regRdData == ($past(regWrData, 3) & dcfr_pkg::CLIP_CTL_WMASK))
		else $error("clip control readback wrong");
	clip_status_a: assert property (@(posedge mclk) disable iff (!nrst)
		!clipCtl[dcfr_pkg::CLIP_EN_BIT] && !$past(clipCtl[dcfr_pkg::CLIP_EN_BIT]) |-> clipStatus == 4'h0)
		else $error("clip flagged while detector off");
	diag_load_a: assert property (@(posedge mclk) disable iff (!nrst)
		diagValid |=> stimulusResultUpper == $past(stimIn[15:8]) && phaseHi == $past(phaseIn[15:8]))
		else $error("diagnostic result not captured");
	therm_latch_a: assert property (@(posedge mclk) disable iff (!nrst)
		thermalShutdown && !miscCtl[dcfr_pkg::MISC_THERM_AUTO_BIT] && !faultClear |=> thermalShutdown)
		else $error("thermal fault not latched");
	hiz_fault_a: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(|limitFault) |=> outputsHiZ)
		else $error("outputs not high impedance on current-limit fault");
	mask_warn_a: assert property (@(posedge mclk) disable iff (!nrst)
		miscCtl[dcfr_pkg::MISC_ILIM_MASK_BIT] && clipPinSrc == 4'h0 |=> !warnPin)
		else $error("masked current-limit warning reached the pin");
	route_split_a: assert property (@(posedge mclk) disable iff (!nrst)
		clipCtl[dcfr_pkg::CLIP_ROUTE_BIT] && clipPinSrc[3:2] != 2'h0 |=> faultPin)
		else $error("channels 3-4 clip not on fault pin");
	// exported copies trail the register by one cycle
	thr_follow_a: assert property (@(posedge mclk) disable iff (!nrst)
		wrClip |=> ##1 clipThreshold == $past(regWrData[dcfr_pkg::CLIP_LEVEL_LSB +: 2], 2))
		else $error("clip threshold does not follow the write");
	det_follow_a: assert property (@(posedge mclk) disable iff (!nrst)
		wrClip |=> ##1 clippingDetectorOn == $past(regWrData[dcfr_pkg::CLIP_EN_BIT], 2))
		else $error("detector enable does not follow the write");
	clip_live_a: assert property (@(posedge mclk) disable iff (!nrst)
		clipCtl[dcfr_pkg::CLIP_EN_BIT] |=> clipStatus == $past(clipRaw))
		else $error("clip status does not show the comparators");
	stat_reserved_a: assert property (@(posedge mclk) disable iff (!nrst)
		regRdEn && regAddr == dcfr_pkg::ADDR_CLIP_STAT |=> regRdData[7:4] == 4'h0)
		else $error("clip status reserved bits read nonzero");
	therm_auto_a: assert property (@(posedge mclk) disable iff (!nrst)
		miscCtl[dcfr_pkg::MISC_THERM_AUTO_BIT] |=> thermalShutdown == $past(overTemp))
		else $error("self-recover shutdown does not track the sensor");
	warn_unmask_a: assert property (@(posedge mclk) disable iff (!nrst)
		!miscCtl[dcfr_pkg::MISC_ILIM_MASK_BIT] && (|limitWarn) |=> warnPin)
		else $error("unmasked current-limit warning missing on the pin");
endmodule
`default_nettype wire

//--- verif/dcfr_host_model.sv
// host-side model driving the register byte port
`timescale 1ns/1ps
`default_nettype none
module dcfr_host_model (
	input wire logic mclk,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrEn,
	output logic regRdEn,
	input wire logic [7:0] regRdData
);
	initial begin
		regAddr = 8'hFF;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
	end
	// enter just after an edge; an idle cycle follows so strobes never re-rise in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1; // fault clear is a one-strobe write of bit 7
		@(posedge mclk);
		#1;
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~d; // released lines show the inverse, not a stale value
		@(posedge mclk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		regAddr = a;
		regRdEn = 1'b1;
		@(posedge mclk);
		#1;
		d = regRdData;
		regRdEn = 1'b0;
		regAddr = ~a;
		@(posedge mclk);
		#1;
	endtask
endmodule
`default_nettype wire

//--- verif/dcfr_regs_bench.sv
// self-checking bench for the diagnostic, clip and fault report registers
`timescale 1ns/1ps
`default_nettype none
module dcfr_regs_bench;
	logic mclk;
	logic nrst = 1'b0;
	logic [7:0] regAddr, regWrData, regRdData, rdv, d;
	logic regWrEn, regRdEn, warnPin, faultPin, hiZ, thermSd, cdOn;
	logic [1:0] clipThr;
	logic diagValid = 1'b0;
	logic [15:0] ph = 16'h0000;
	logic [15:0] st = 16'h0000;
	logic [3:0] clipRaw = 4'h0;
	logic [3:0] limitEvent = 4'h0;
	logic [3:0] c;
	logic overTemp = 1'b0;
	logic latchEn = 1'b0;
	logic ilimRun = 1'b0;
	int cyc = 0;
	int n_errors = 0;
	int comparisons = 0;
	logic [7:0] addrs [9] = '{8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h21, 8'h22, 8'h24, 8'h25, 8'h30};
	logic [7:0] resets [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
	dcfr_regs #(.WINDOW_CYCLES(20), .CHANNELS(4)) uut (.mclk(mclk), .nrst(nrst),
		.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .diagValid(diagValid), .phaseIn(ph), .stimIn(st),
		.clipRaw(clipRaw), .limitEvent(limitEvent), .overTemp(overTemp),
		.clipPinLatchEn(latchEn), .warnPin(warnPin), .faultPin(faultPin),
		.outputsHiZ(hiZ), .thermalShutdown(thermSd), .clippingDetectorOn(cdOn),
		.clipThreshold(clipThr));
	dcfr_host_model host (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));
	// only writable bits survive; write-1 clear reads back zero
	function automatic logic [7:0] expRd(input logic [7:0] a, input logic [7:0] w);
		case (a)
			8'h21: return w & 8'h28;
			8'h22: return w & 8'h17;
			default: return 8'h00;
		endcase
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, rdv);
		check(rdv, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wrap_up();
		$display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// ch1 always, ch2 half (10 of 20, just over), ch3 never, ch4 a third (under)
	always @(posedge mclk) begin
		#1;
		cyc++;
		limitEvent = ilimRun ? {cyc % 3 == 0, 1'b0, cyc[0], 1'b1} : 4'h0;
	end
	initial begin
		#100000;
		n_errors++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'hC31403C9));
		tick(16);
		nrst = 1'b1;
		check({7'h00, cdOn}, 8'h01);
		foreach (addrs[i]) rdChk(addrs[i], resets[i]);
		for (int j = 0; j < 2; j++) begin
			foreach (addrs[i]) begin
				d = j ? 8'hFF : 8'($urandom());
				host.wr(addrs[i], d);
				rdChk(addrs[i], expRd(addrs[i], d));
			end
		end
		for (int i = 0; i < 4; i++) begin
			host.wr(8'h22, 8'(i * 2 + 1));
			tick(1);
			check({6'h00, clipThr}, 8'(i));
		end
		ph = 16'($urandom());
		st = 16'($urandom());
		diagValid = 1'b1;
		tick(1);
		diagValid = 1'b0;
		ph = ~ph;
		st = ~st;
		rdChk(8'h1E, ~st[7:0]);
		rdChk(8'h1D, ~st[15:8]);
		rdChk(8'h1C, ~ph[7:0]);
		rdChk(8'h1B, ~ph[15:8]);
		rdChk(8'h1C, ~ph[7:0]);
		host.wr(8'h21, 8'h20);
		host.wr(8'h22, 8'h01);
		c = 4'($urandom()) | 4'h4;
		clipRaw = c;
		tick(2);
		rdChk(8'h24, {4'h0, c});
		check({warnPin, faultPin}, 8'h02);
		host.wr(8'h22, 8'h11);
		tick(2);
		check({warnPin, faultPin}, {6'h00, |c[1:0], 1'b1});
		host.wr(8'h22, 8'h10);
		tick(2);
		rdChk(8'h24, 8'h00);
		check({cdOn, warnPin, faultPin}, 8'h00);
		latchEn = 1'b1;
		clipRaw = 4'h1;
		host.wr(8'h22, 8'h01);
		tick(2);
		clipRaw = 4'h0;
		tick(3);
		check({7'h00, warnPin}, 8'h01);
		host.wr(8'h21, 8'hA0);
		tick(3);
		check({7'h00, warnPin}, 8'h00);
		latchEn = 1'b0;
		overTemp = 1'b1;
		tick(2);
		overTemp = 1'b0;
		tick(3);
		check({thermSd, faultPin}, 8'h03);
		host.wr(8'h21, 8'hA0);
		tick(3);
		check({7'h00, thermSd}, 8'h00);
		host.wr(8'h21, 8'h08);
		overTemp = 1'b1;
		tick(3);
		check({7'h00, thermSd}, 8'h01);
		overTemp = 1'b0;
		tick(3);
		check({7'h00, thermSd}, 8'h00);
		host.wr(8'h21, 8'h00);
		ilimRun = 1'b1;
		tick(70);
		check({hiZ, warnPin}, 8'h01);
		rdChk(8'h25, 8'h03);
		tick(80);
		rdChk(8'h25, 8'h33);
		check({hiZ, faultPin}, 8'h03);
		host.wr(8'h21, 8'h20);
		tick(3);
		check({7'h00, warnPin}, 8'h00);
		ilimRun = 1'b0;
		tick(65);
		rdChk(8'h25, 8'h30);
		host.wr(8'h21, 8'hA0);
		tick(2);
		rdChk(8'h25, 8'h00);
		check({7'h00, hiZ}, 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
